/* File: verilog/keypad_cfg.svh */
// Purpose: register offsets, field positions and reset values of the keypad interrupt unit
// Assumes: 8-bit register data, byte addresses as printed
// Notes:   definitions only
`ifndef KEYPAD_CFG_SVH
`define KEYPAD_CFG_SVH

`define KEY_ADDR_W           16
`define KEY_DATA_W           8
`define KEY_OFS_STATUS_CTRL  16'h001A
`define KEY_OFS_IRQ_ENABLE   16'h001B
`define KEY_OFS_POLARITY     16'h001C
`define KEY_OFS_IRQ_STATUS   16'h001D
`define KEY_OFS_IRQ_MASK     16'h001E
`define KEY_BIT_MODE         0
`define KEY_BIT_MASK         1
`define KEY_BIT_ACK          2
`define KEY_BIT_FLAG         3
`define KEY_BIT_WAKE         6
`define KEY_BIT_EV_LATCH     0
`define KEY_BIT_EV_EDGE      1
`define KEY_RESET_BYTE       8'h00
`define KEY_RESET_PINS       6'h00

`endif

/* File: verilog/keypad_pkg.sv */
// Purpose: shared types of the keypad interrupt unit
// Assumes: six key pins
// Notes:   constants live in keypad_cfg.svh
package keypad_pkg;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_type;

    typedef struct packed {
        logic [5:0] pull_up_en;
        logic [5:0] pull_down_en;
    } pull_ctrl_type;

endpackage

/* File: verilog/keypad_interrupt_unit.sv */
// Purpose: keypad interrupt unit, six shared pins into one latched request
// Assumes: key_pins already synchronous to ref_clk; register port with read data one cycle later
// Notes:   extra event status/mask registers at 0x1D/0x1E drive event_irq
`timescale 1ns/1ps
`include "keypad_cfg.svh"

module keypad_interrupt_unit
    import keypad_pkg::*;
#(
    parameter int PINS = 6
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst_b,
    input  wire logic [`KEY_ADDR_W-1:0]  reg_addr,
    input  wire logic [`KEY_DATA_W-1:0]  reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`KEY_DATA_W-1:0]  reg_rdata,
    input  wire logic [PINS-1:0]         key_pins,
    output logic      [PINS-1:0]         pull_up_en,
    output logic      [PINS-1:0]         pull_down_en,
    output logic                         key_irq,
    output logic                         wakeup_irq_enable,
    output logic                         event_irq
);

    reg_req_type      req;
    logic [PINS-1:0]  pin_irq_enable_r;
    logic [PINS-1:0]  pin_polarity_select_r;
    logic             wakeup_irq_enable_r;
    logic             sense_mode_select_r;
    logic             request_mask_r;
    logic             latch_r;
    logic [PINS-1:0]  asserted_prev_r;
    logic [1:0]       ev_status_r;
    logic [1:0]       ev_mask_r;
    logic [PINS-1:0]  asserted;
    logic [PINS-1:0]  new_edge;
    logic             any_asserted;
    logic             edge_hit;
    logic             latch_set;
    logic             ack_wr;
    logic             latch_nxt;
    pull_ctrl_type    pull_nxt;

    // full-address equality compare used for every register write and read
    function automatic logic hit(input logic [`KEY_ADDR_W-1:0] a, input logic [`KEY_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // asserted level per pin: polarity 1 means high, 0 means low, only when enabled
    assign asserted     = pin_irq_enable_r & ~(key_pins ^ pin_polarity_select_r);
    assign any_asserted = |asserted;
    assign new_edge     = asserted & ~asserted_prev_r;

    // an edge counts only if no other enabled input was already asserted
    assign edge_hit = (new_edge != '0) && ((asserted_prev_r & asserted) == '0);

    // mode 1 keeps setting while held, mode 0 only takes edges
    assign latch_set = sense_mode_select_r ? any_asserted : edge_hit;

    assign ack_wr = req.wr && hit(req.addr, `KEY_OFS_STATUS_CTRL) && req.wdata[`KEY_BIT_ACK];

    // set beats acknowledge, so a held level or a same-cycle edge is never lost
    always_comb begin
        latch_nxt = latch_r;
        if (ack_wr) begin
            latch_nxt = 1'b0;
        end
        if (latch_set) begin
            latch_nxt = 1'b1;
        end
    end

    // pull devices follow polarity of each enabled pin
    always_comb begin
        pull_nxt.pull_up_en   = pin_irq_enable_r & ~pin_polarity_select_r;
        pull_nxt.pull_down_en = pin_irq_enable_r & pin_polarity_select_r;
    end

    // shared latch and edge history
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            latch_r         <= 1'b0;
            asserted_prev_r <= `KEY_RESET_PINS;
        end else begin
            latch_r         <= latch_nxt;
            asserted_prev_r <= asserted;
        end
    end

    // status/control writable bits
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sense_mode_select_r <= 1'b0;
            request_mask_r      <= 1'b0;
        end else if (req.wr && hit(req.addr, `KEY_OFS_STATUS_CTRL)) begin
            sense_mode_select_r <= req.wdata[`KEY_BIT_MODE];
            request_mask_r      <= req.wdata[`KEY_BIT_MASK];
        end
    end

    // enable and polarity registers
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_irq_enable_r      <= `KEY_RESET_PINS;
            wakeup_irq_enable_r   <= 1'b0;
            pin_polarity_select_r <= `KEY_RESET_PINS;
        end else begin
            if (req.wr && hit(req.addr, `KEY_OFS_IRQ_ENABLE)) begin
                pin_irq_enable_r    <= req.wdata[PINS-1:0];
                wakeup_irq_enable_r <= req.wdata[`KEY_BIT_WAKE];
            end
            if (req.wr && hit(req.addr, `KEY_OFS_POLARITY)) begin
                pin_polarity_select_r <= req.wdata[PINS-1:0];
            end
        end
    end

    // event status: latch set and accepted edge; write one to clear, set wins
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ev_status_r <= 2'h0;
            ev_mask_r   <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (req.wr && hit(req.addr, `KEY_OFS_IRQ_STATUS) && req.wdata[i]) begin
                    ev_status_r[i] <= 1'b0;
                end
            end
            if (latch_set && !latch_r) begin
                ev_status_r[`KEY_BIT_EV_LATCH] <= 1'b1;
            end
            if (edge_hit) begin
                ev_status_r[`KEY_BIT_EV_EDGE] <= 1'b1;
            end
            if (req.wr && hit(req.addr, `KEY_OFS_IRQ_MASK)) begin
                ev_mask_r <= req.wdata[1:0];
            end
        end
    end

    // registered outputs; mask only gates the request, latch keeps running
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            key_irq           <= 1'b0;
            pull_up_en        <= `KEY_RESET_PINS;
            pull_down_en      <= `KEY_RESET_PINS;
            wakeup_irq_enable <= 1'b0;
            event_irq         <= 1'b0;
        end else begin
            key_irq           <= latch_nxt && !request_mask_r;
            pull_up_en        <= pull_nxt.pull_up_en;
            pull_down_en      <= pull_nxt.pull_down_en;
            wakeup_irq_enable <= wakeup_irq_enable_r;
            event_irq         <= |(ev_status_r & ev_mask_r);
        end
    end

    // read port: data one cycle after the strobe, unmapped reads zero
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= `KEY_RESET_BYTE;
        end else if (req.rd) begin
            reg_rdata <= `KEY_RESET_BYTE;
            if (hit(req.addr, `KEY_OFS_STATUS_CTRL)) begin
                reg_rdata[`KEY_BIT_FLAG] <= latch_r;
                reg_rdata[`KEY_BIT_MASK] <= request_mask_r;
                reg_rdata[`KEY_BIT_MODE] <= sense_mode_select_r;
            end else if (hit(req.addr, `KEY_OFS_IRQ_ENABLE)) begin
                reg_rdata[PINS-1:0]      <= pin_irq_enable_r;
                reg_rdata[`KEY_BIT_WAKE] <= wakeup_irq_enable_r;
            end else if (hit(req.addr, `KEY_OFS_POLARITY)) begin
                reg_rdata[PINS-1:0] <= pin_polarity_select_r;
            end else if (hit(req.addr, `KEY_OFS_IRQ_STATUS)) begin
                reg_rdata[1:0] <= ev_status_r;
            end else if (hit(req.addr, `KEY_OFS_IRQ_MASK)) begin
                reg_rdata[1:0] <= ev_mask_r;
            end
        end else begin
            reg_rdata <= `KEY_RESET_BYTE;
        end
    end

endmodule // keypad_interrupt_unit

/* File: testbench/keypad_sva.sv */
// Purpose: port-level checks of the keypad interrupt unit
// Assumes: read data stands one cycle after the read strobe
// Notes:   bound to every instance of the unit
`timescale 1ns/1ps
module keypad_sva
    import keypad_pkg::*;
#(parameter int PINS = 6) (
    input wire logic             ref_clk,
    input wire logic             rst_b,
    input wire logic [15:0]      reg_addr,
    input wire logic [7:0]       reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [7:0]       reg_rdata,
    input wire logic [PINS-1:0]  key_pins,
    input wire logic [PINS-1:0]  pull_up_en,
    input wire logic [PINS-1:0]  pull_down_en,
    input wire logic             key_irq,
    input wire logic             wakeup_irq_enable
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // a read of one address, answered at the following edge
    sequence s_read(a);
        reg_rd && reg_addr == a;
    endsequence
    sequence s_mask_on;
        reg_wr && reg_addr == 16'h001A && reg_wdata[1];
    endsequence
    chk_status_spare: assert property (s_read(16'h001A) |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[2])
        else $error("status spare bits set");
    chk_enable_top: assert property (s_read(16'h001B) |=> !reg_rdata[7])
        else $error("enable bit 7 set");
    chk_polarity_top: assert property (s_read(16'h001C) |=> reg_rdata[7:6] == 2'h0)
        else $error("polarity top bits set");
    chk_pull_excl: assert property ((pull_up_en & pull_down_en) == '0)
        else $error("pull-up and pull-down together");
    // pulls only follow register writes, never the pins
    chk_pull_cause: assert property ($changed(pull_up_en) || $changed(pull_down_en)
        |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3)) else $error("pull changed unprompted");
    chk_mask_hold: assert property (s_mask_on |-> ##2 !key_irq [*2])
        else $error("request seen while masked");
    chk_irq_cause: assert property ($rose(key_irq) |-> key_pins != $past(key_pins)
        || $past(key_pins) != $past(key_pins, 2)
        || $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3)) else $error("request without cause");
    chk_wake_cause: assert property ($changed(wakeup_irq_enable) |-> $past(reg_wr) || $past(reg_wr, 2))
        else $error("wakeup enable changed unprompted");
endmodule // keypad_sva
bind keypad_interrupt_unit keypad_sva #(.PINS(PINS)) i_sva (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .key_pins, .pull_up_en, .pull_down_en, .key_irq, .wakeup_irq_enable);

/* File: testbench/keypad_switches.sv */
// Purpose: six keypad switches on the shared pins
// Assumes: a pressed switch overrides the pull device
// Notes:   a floating pin flips every cycle so a missing pull shows
`timescale 1ns/1ps
module keypad_switches (
    input wire logic        ref_clk,
    input wire logic [5:0]  press,
    input wire logic [5:0]  press_lvl,
    input wire logic [5:0]  pull_up_en,
    input wire logic [5:0]  pull_down_en,
    output logic     [5:0]  key_pins
);
    logic [5:0] float_r = 6'h15;
    // undriven lines wander instead of settling on the simulator's choice
    always_ff @(posedge ref_clk) begin
        float_r <= ~float_r;
    end
    // switch beats pull, pull beats floating
    assign key_pins = (press & press_lvl) | (~press & (pull_up_en | (~pull_down_en & float_r)));
endmodule // keypad_switches

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench of the keypad interrupt unit
// Assumes: switches model on the pins
// Notes:   fixed waits follow the latch latency of the unit
`timescale 1ns/1ps
module tb_top;
    logic        ref_clk = 0;
    logic        rst_b = 0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata;
    logic        reg_wr = 0, reg_rd = 0, key_irq, wake, event_irq;
    logic [5:0]  key_pins, pull_up_en, pull_down_en, press = 6'h00, press_lvl = 6'h00;
    int          err_total = 0, num_checks = 0;
    always #5 ref_clk = ~ref_clk;
    keypad_interrupt_unit #(.PINS(6)) i_dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .key_pins, .pull_up_en, .pull_down_en, .key_irq, .wakeup_irq_enable(wake), .event_irq);
    keypad_switches i_keys (.ref_clk, .press, .press_lvl, .pull_up_en, .pull_down_en, .key_pins);
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", reg_rdata, exp);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_regs;
        rd(16'h001A, 8'h00);
        rd(16'h001B, 8'h00);
        wr(16'h001B, 8'hFF);
        wr(16'h001C, 8'hFF);
        wr(16'h001A, 8'hFF);
        rd(16'h001B, 8'h7F);
        rd(16'h001C, 8'h3F);
        rd(16'h001A, 8'h03);
        rd(16'h001F, 8'h00);
        chk("pull_down_en", {2'b00, pull_down_en}, 8'h3F);
        chk("wake", {7'h00, wake}, 8'h01);
        wr(16'h001C, 8'h05);
        tick(2);
        chk("pull_up_en", {2'b00, pull_up_en}, 8'h3A);
    endtask
    task automatic t_edge;
        wr(16'h001C, 8'h00);
        wr(16'h001B, 8'h03);
        wr(16'h001A, 8'h04);
        press <= 6'h01;
        tick(3);
        chk("key_irq", {7'h00, key_irq}, 8'h01);
        rd(16'h001A, 8'h08);
        wr(16'h001A, 8'h04);
        press <= 6'h03;
        tick(3);
        chk("key_irq", {7'h00, key_irq}, 8'h00);
        wr(16'h001B, 8'h02);
        press <= 6'h01;
        wr(16'h001D, 8'h03);
        wr(16'h001E, 8'h00);
        press <= 6'h03;
        tick(3);
        chk("key_irq", {7'h00, key_irq}, 8'h01);
        rd(16'h001D, 8'h03);
        wr(16'h001E, 8'h01);
        tick(2);
        chk("event_irq", {7'h00, event_irq}, 8'h01);
        wr(16'h001D, 8'h03);
        press <= 6'h00;
        tick(2);
        chk("event_irq", {7'h00, event_irq}, 8'h00);
    endtask
    // mid-run reset: pull_up_en and the registers at 0x1A to 0x1C must return to their reset values
    task automatic t_reset;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        tick(1);
        chk("pull_up_en", {2'b00, pull_up_en}, 8'h00);
        rd(16'h001A, 8'h00);
        rd(16'h001B, 8'h00);
        rd(16'h001C, 8'h00);
    endtask
    task automatic t_level;
        wr(16'h001B, 8'h04);
        wr(16'h001C, 8'h04);
        press_lvl <= 6'h04;
        press <= 6'h04;
        wr(16'h001A, 8'h05);
        wr(16'h001A, 8'h05);
        rd(16'h001A, 8'h09);
        wr(16'h001A, 8'h03);
        tick(2);
        chk("key_irq", {7'h00, key_irq}, 8'h00);
        rd(16'h001A, 8'h0B);
        wr(16'h001E, 8'h00);
        press <= 6'h00;
        wr(16'h001A, 8'h05);
        rd(16'h001A, 8'h01);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_regs;
        t_edge;
        t_reset;
        t_level;
        summarize;
    end
    // the whole sequence needs well under 200 cycles
    initial begin
        #20000;
        err_total++;
        summarize;
    end
endmodule // tb_top
